// ### hbc_cfg.svh
// Register map, field positions, reset values and timing figures of the
// H-bridge configuration bank.
// Assumes a 50 MHz device clock; included by bare name.
`ifndef HBC_CFG_SVH
`define HBC_CFG_SVH

`define HBC_ADDR_W 8
`define HBC_DATA_W 8

`define HBC_ADDR_MAIN 8'h02
`define HBC_ADDR_GATE 8'h03
`define HBC_ADDR_MON 8'h04
`define HBC_ADDR_REG 8'h05

`define HBC_RST_GATE 8'h07
`define HBC_RST_MON 8'h70
`define HBC_RST_REG 8'h01

`define HBC_LOCK_MSB 5
`define HBC_LOCK_LSB 3
`define HBC_LOCK_CODE 3'h6
`define HBC_UNLOCK_CODE 3'h3

`define HBC_CLK_MHZ 50
`define HBC_DEAD_NS_0 120
`define HBC_DEAD_NS_1 240
`define HBC_DEAD_NS_2 480
`define HBC_DEAD_NS_3 960
`define HBC_WDOG_MS_0 10
`define HBC_WDOG_MS_1 20
`define HBC_WDOG_MS_2 50
`define HBC_WDOG_MS_3 100
`define HBC_CHOP_OFF_TIME_SEL_US_0 25
`define HBC_CHOP_OFF_TIME_SEL_US_1 50
`define HBC_CHOP_OFF_TIME_SEL_US_2 100
`define HBC_CHOP_OFF_TIME_SEL_US_3 200

`endif

// ### hbc_pkg.sv
// Field layouts of the three configuration registers.
// Assumes hbc_cfg.svh for offsets and reset values.
package hbc_pkg;
    typedef struct packed {
        logic [1:0] dead_time_sel;
        logic wdog_on;
        logic [1:0] wdog_period_sel;
        logic [2:0] gate_current_sel;
    } hbc_gate_t;

    typedef struct packed {
        logic sense_out_clamp;
        logic [2:0] overcurrent_trip_sel;
        logic hb2_high_monitor_off;
        logic hb2_low_monitor_off;
        logic hb1_high_monitor_off;
        logic hb1_low_monitor_off;
    } hbc_mon_t;

    typedef struct packed {
        logic [1:0] chop_off_time_sel;
        logic regulation_off;
        logic [1:0] ref_scale_sel;
        logic sample_hold_on;
        logic [1:0] amp_gain_sel;
    } hbc_reg_t;

    typedef enum logic [0:0] {
        HBC_OPEN,
        HBC_LOCKED
    } hbc_lock_t;
endpackage : hbc_pkg

// ### hbc_timing.sv
// Turns the timing selectors into clock-cycle counts at the device clock.
// Assumes the selectors come straight from the configuration registers.
`timescale 1ns/1ns
`default_nettype none
`include "hbc_cfg.svh"
module hbc_timing (
    input wire logic [1:0] dead_sel_i,
    input wire logic [1:0] wdog_sel_i,
    input wire logic [1:0] chop_off_time_sel_sel_i,
    output logic [5:0] dead_cycles_o,
    output logic [22:0] wdog_cycles_o,
    output logic [13:0] chop_off_time_sel_cycles_o
);
    // Dead time is a least time: round up
    localparam int DC0 = (`HBC_DEAD_NS_0 * `HBC_CLK_MHZ + 999) / 1000;
    localparam int DC1 = (`HBC_DEAD_NS_1 * `HBC_CLK_MHZ + 999) / 1000;
    localparam int DC2 = (`HBC_DEAD_NS_2 * `HBC_CLK_MHZ + 999) / 1000;
    localparam int DC3 = (`HBC_DEAD_NS_3 * `HBC_CLK_MHZ + 999) / 1000;
    localparam int WC0 = `HBC_WDOG_MS_0 * `HBC_CLK_MHZ * 1000;
    localparam int WC1 = `HBC_WDOG_MS_1 * `HBC_CLK_MHZ * 1000;
    localparam int WC2 = `HBC_WDOG_MS_2 * `HBC_CLK_MHZ * 1000;
    localparam int WC3 = `HBC_WDOG_MS_3 * `HBC_CLK_MHZ * 1000;
    localparam int TC0 = `HBC_CHOP_OFF_TIME_SEL_US_0 * `HBC_CLK_MHZ;
    localparam int TC1 = `HBC_CHOP_OFF_TIME_SEL_US_1 * `HBC_CLK_MHZ;
    localparam int TC2 = `HBC_CHOP_OFF_TIME_SEL_US_2 * `HBC_CLK_MHZ;
    localparam int TC3 = `HBC_CHOP_OFF_TIME_SEL_US_3 * `HBC_CLK_MHZ;

    function automatic logic [31:0] pick4(input logic [1:0] s, input int a, input int b,
                                          input int c, input int d);
        case (s)
            2'h0: pick4 = 32'(a);
            2'h1: pick4 = 32'(b);
            2'h2: pick4 = 32'(c);
            default: pick4 = 32'(d);
        endcase
    endfunction : pick4

    wire logic [31:0] dead_w = pick4(dead_sel_i, DC0, DC1, DC2, DC3);
    wire logic [31:0] wdog_w = pick4(wdog_sel_i, WC0, WC1, WC2, WC3);
    wire logic [31:0] chop_off_time_sel_w = pick4(chop_off_time_sel_sel_i, TC0, TC1, TC2, TC3);

    assign dead_cycles_o = dead_w[5:0];
    assign wdog_cycles_o = wdog_w[22:0];
    assign chop_off_time_sel_cycles_o = chop_off_time_sel_w[13:0];
endmodule : hbc_timing
`default_nettype wire

// ### hbc_config_regs.sv
// Configuration register bank of the H-bridge gate driver: main control
// lock state plus the gate timing, monitor and regulation registers.
// Assumes a serial front end that presents one synchronous byte write or
// read strobe per access, already decoded to address and data.
`timescale 1ns/1ns
`default_nettype none
`include "hbc_cfg.svh"
module hbc_config_regs (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    output logic locked_o,
    output logic [1:0] dead_time_sel_o,
    output logic [5:0] dead_cycles_o,
    output logic wdog_on_o,
    output logic [22:0] wdog_cycles_o,
    output logic [2:0] gate_current_sel_o,
    output logic sense_out_clamp_o,
    output logic [2:0] overcurrent_trip_sel_o,
    output logic [3:0] monitor_off_o,
    output logic [13:0] chop_off_time_sel_cycles_o,
    output logic regulation_off_o,
    output logic [1:0] ref_scale_sel_o,
    output logic sample_hold_on_o,
    output logic [1:0] amp_gain_sel_o
);
    hbc_pkg::hbc_gate_t gate_reg;
    hbc_pkg::hbc_gate_t gate_next;
    hbc_pkg::hbc_mon_t mon_reg;
    hbc_pkg::hbc_mon_t mon_next;
    hbc_pkg::hbc_reg_t regu_reg;
    hbc_pkg::hbc_reg_t regu_next;
    hbc_pkg::hbc_lock_t lock_reg;
    hbc_pkg::hbc_lock_t lock_next;
    logic [7:0] rdata_reg;
    logic rvalid_reg;
    logic [5:0] dead_cyc_reg;
    logic [22:0] wdog_cyc_reg;
    logic [13:0] chop_off_time_sel_cyc_reg;
    logic [7:0] rdata_next;
    logic rvalid_next;
    logic [5:0] dead_cyc_next;
    logic [22:0] wdog_cyc_next;
    logic [13:0] chop_off_time_sel_cyc_next;

    // One comparator shape for every decode, so the write and read maps agree
    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] target);
        addr_hit = (a == target);
    endfunction : addr_hit

    wire logic [2:0] lock_field = wdata_i[`HBC_LOCK_MSB:`HBC_LOCK_LSB];
    wire logic hit_main = addr_hit(addr_i, `HBC_ADDR_MAIN);
    wire logic hit_gate = addr_hit(addr_i, `HBC_ADDR_GATE);
    wire logic hit_mon = addr_hit(addr_i, `HBC_ADDR_MON);
    wire logic hit_regu = addr_hit(addr_i, `HBC_ADDR_REG);
    wire logic wr_main = wr_i && hit_main;
    wire logic open_w = (lock_reg == hbc_pkg::HBC_OPEN);
    // Only the lock state of the main control register lives here
    wire logic [7:0] main_rd = {2'h0, (open_w ? `HBC_UNLOCK_CODE : `HBC_LOCK_CODE), 3'h0};
    // A locked bank drops the write silently; the host gets no error back
    wire logic wr_gate = wr_i && open_w && hit_gate;
    wire logic wr_mon = wr_i && open_w && hit_mon;
    wire logic wr_regu = wr_i && open_w && hit_regu;
    // Each code acts only in the state it leaves; any other code is ignored
    wire logic lock_req = wr_main && open_w && (lock_field == `HBC_LOCK_CODE);
    wire logic unlock_req = wr_main && !open_w && (lock_field == `HBC_UNLOCK_CODE);

    wire logic [7:0] rd_mux =
        hit_main ? main_rd :
        hit_gate ? gate_reg :
        hit_mon ? mon_reg :
        hit_regu ? regu_reg : 8'h00;

    always_comb begin
        lock_next = lock_reg;
        if (lock_req) begin
            lock_next = hbc_pkg::HBC_LOCKED;
        end else if (unlock_req) begin
            lock_next = hbc_pkg::HBC_OPEN;
        end
    end

    assign gate_next = wr_gate ? hbc_pkg::hbc_gate_t'(wdata_i) : gate_reg;
    assign mon_next = wr_mon ? hbc_pkg::hbc_mon_t'(wdata_i) : mon_reg;
    assign regu_next = wr_regu ? hbc_pkg::hbc_reg_t'(wdata_i) : regu_reg;

    wire logic [5:0] dead_cyc_w;
    wire logic [22:0] wdog_cyc_w;
    wire logic [13:0] chop_off_time_sel_cyc_w;

    hbc_timing u_timing (
        .dead_sel_i(gate_reg.dead_time_sel),
        .wdog_sel_i(gate_reg.wdog_period_sel),
        .chop_off_time_sel_sel_i(regu_reg.chop_off_time_sel),
        .dead_cycles_o(dead_cyc_w),
        .wdog_cycles_o(wdog_cyc_w),
        .chop_off_time_sel_cycles_o(chop_off_time_sel_cyc_w)
    );

    // Counts are registered so consumers never see a decode glitch; they lag one cycle
    assign dead_cyc_next = dead_cyc_w;
    assign wdog_cyc_next = wdog_cyc_w;
    assign chop_off_time_sel_cyc_next = chop_off_time_sel_cyc_w;
    // Read data holds between reads, so a slow host may take it late
    assign rdata_next = rd_i ? rd_mux : rdata_reg;
    assign rvalid_next = rd_i;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            gate_reg <= hbc_pkg::hbc_gate_t'(`HBC_RST_GATE);
        end else begin
            gate_reg <= gate_next;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            mon_reg <= hbc_pkg::hbc_mon_t'(`HBC_RST_MON);
        end else begin
            mon_reg <= mon_next;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            regu_reg <= hbc_pkg::hbc_reg_t'(`HBC_RST_REG);
        end else begin
            regu_reg <= regu_next;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            lock_reg <= hbc_pkg::HBC_OPEN;
        end else begin
            lock_reg <= lock_next;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= rvalid_next;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            dead_cyc_reg <= '0;
        end else begin
            dead_cyc_reg <= dead_cyc_next;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            wdog_cyc_reg <= '0;
        end else begin
            wdog_cyc_reg <= wdog_cyc_next;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            chop_off_time_sel_cyc_reg <= '0;
        end else begin
            chop_off_time_sel_cyc_reg <= chop_off_time_sel_cyc_next;
        end
    end

    assign rdata_o = rdata_reg;
    assign rvalid_o = rvalid_reg;
    assign locked_o = (lock_reg == hbc_pkg::HBC_LOCKED);
    assign dead_time_sel_o = gate_reg.dead_time_sel;
    assign dead_cycles_o = dead_cyc_reg;
    assign wdog_on_o = gate_reg.wdog_on;
    assign wdog_cycles_o = wdog_cyc_reg;
    // Drive strength code goes out raw; 000b weakest, rising monotonically
    assign gate_current_sel_o = gate_reg.gate_current_sel;
    assign sense_out_clamp_o = mon_reg.sense_out_clamp;
    // Threshold codes are not monotonic; the analog side decodes them
    assign overcurrent_trip_sel_o = mon_reg.overcurrent_trip_sel;
    assign monitor_off_o = {mon_reg.hb2_high_monitor_off, mon_reg.hb2_low_monitor_off,
                            mon_reg.hb1_high_monitor_off, mon_reg.hb1_low_monitor_off};
    assign chop_off_time_sel_cycles_o = chop_off_time_sel_cyc_reg;
    assign regulation_off_o = regu_reg.regulation_off;
    assign ref_scale_sel_o = regu_reg.ref_scale_sel;
    assign sample_hold_on_o = regu_reg.sample_hold_on;
    assign amp_gain_sel_o = regu_reg.amp_gain_sel;
endmodule : hbc_config_regs
`default_nettype wire

// ### hbc_config_regs_assertions.sv
// Concurrent checks on the ports of the configuration bank.
// Assumes one clock and a synchronous active-high reset; bound by name.
`timescale 1ns/1ns
`default_nettype none
module hbc_cfg_chk (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic rvalid_o,
    input wire logic locked_o,
    input wire logic [1:0] dead_time_sel_o,
    input wire logic [5:0] dead_cycles_o,
    input wire logic wdog_on_o,
    input wire logic [2:0] gate_current_sel_o,
    input wire logic [3:0] monitor_off_o,
    input wire logic [13:0] chop_off_time_sel_cycles_o,
    input wire logic [1:0] amp_gain_sel_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    wire open_wr = !locked_o && wr_i;
    wire mainw = wr_i && addr_i == 8'h02;
    property p_rvalid; rd_i |=> rvalid_o; endproperty
    a_rvalid: assert property (p_rvalid) else $error("read not answered");
    property p_no_rvalid; !rd_i |=> !rvalid_o; endproperty
    a_no_rvalid: assert property (p_no_rvalid) else $error("stray read valid");
    // Counts lag the field by one cycle, so skip the edge right after reset
    property p_dead;
        !$past(srst_i) |-> dead_cycles_o == (6'd6 << $past(dead_time_sel_o));
    endproperty
    a_dead: assert property (p_dead) else $error("dead time count wrong");
    property p_gate_wr;
        open_wr && addr_i == 8'h03 |=> {dead_time_sel_o, wdog_on_o, gate_current_sel_o}
            == {$past(wdata_i[7:5]), $past(wdata_i[2:0])};
    endproperty
    a_gate_wr: assert property (p_gate_wr) else $error("gate write lost");
    property p_chop_off_time_sel;
        open_wr && addr_i == 8'h05 |-> ##2 chop_off_time_sel_cycles_o == (14'd1250 << $past(wdata_i[7:6], 2));
    endproperty
    a_chop_off_time_sel: assert property (p_chop_off_time_sel) else $error("off time count wrong");
    property p_gain; open_wr && addr_i == 8'h05 |=> amp_gain_sel_o == $past(wdata_i[1:0]); endproperty
    a_gain: assert property (p_gain) else $error("gain write lost");
    property p_mon_hold; !(wr_i && addr_i == 8'h04) |=> $stable(monitor_off_o); endproperty
    a_mon_hold: assert property (p_mon_hold) else $error("monitor field moved");
    property p_locked_wr; locked_o && wr_i && addr_i == 8'h04 |=> $stable(monitor_off_o); endproperty
    a_locked_wr: assert property (p_locked_wr) else $error("locked write taken");
    property p_lock_set; !locked_o && mainw && wdata_i[5:3] == 3'h6 |=> locked_o; endproperty
    a_lock_set: assert property (p_lock_set) else $error("lock not set");
    property p_lock_keep; locked_o && mainw && wdata_i[5:3] != 3'h3 |=> locked_o; endproperty
    a_lock_keep: assert property (p_lock_keep) else $error("lock dropped");
    c_read: cover property (rd_i ##1 rvalid_o);
    c_lock: cover property (!locked_o ##1 locked_o);
    c_refused: cover property (locked_o && wr_i && addr_i == 8'h04);
endmodule : hbc_cfg_chk
bind hbc_config_regs hbc_cfg_chk i_hbc_cfg_chk (.*);
`default_nettype wire

// ### hbc_host.sv
// Host model: issues one-cycle write and read strobes at falling edges.
// Assumes the bank answers a read one cycle after the strobe.
`timescale 1ns/1ns
`default_nettype none
module hbc_host (
    input wire logic ref_clk_i,
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i
);
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end
    // Released lines show the inverse so stale values never look valid
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk_i);
        wr_o = 1'b1;
        addr_o = a;
        wdata_o = d;
        @(negedge ref_clk_i);
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask : write_reg
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge ref_clk_i);
        rd_o = 1'b1;
        addr_o = a;
        @(negedge ref_clk_i);
        rd_o = 1'b0;
        addr_o = ~a;
        d = rdata_i;
        v = rvalid_i;
    endtask : read_reg
endmodule : hbc_host
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the configuration bank, driven by the host model.
// Assumes hbc_cfg.svh for the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "hbc_cfg.svh"
module testbench;
    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic wr_i, rd_i, rvalid_o, locked_o, wdog_on_o, sense_out_clamp_o, v;
    logic regulation_off_o, sample_hold_on_o;
    logic [7:0] addr_i, wdata_i, rdata_o, d, g, m, r;
    logic [1:0] dead_time_sel_o, ref_scale_sel_o, amp_gain_sel_o;
    logic [2:0] gate_current_sel_o, overcurrent_trip_sel_o;
    logic [3:0] monitor_off_o;
    logic [5:0] dead_cycles_o;
    logic [13:0] chop_off_time_sel_cycles_o;
    logic [22:0] wdog_cycles_o;
    logic [22:0] wd_tab [4] = '{23'd500000, 23'd1000000, 23'd2500000, 23'd5000000};
    int fail_count = 0;
    int checked = 0;
    int cyc = 0;
    always #10 ref_clk_i = ~ref_clk_i;
    hbc_config_regs i_hbc_config_regs (.*);
    hbc_host i_hbc_host (.ref_clk_i(ref_clk_i), .wr_o(wr_i), .rd_o(rd_i), .addr_o(addr_i),
        .wdata_o(wdata_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o));
    task automatic chk(input logic [22:0] got, input logic [22:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        i_hbc_host.read_reg(a, d, v);
        chk(v, 23'd1);
        chk(d, exp);
    endtask : rd_chk
    task automatic report_and_stop;
        if (fail_count == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    task automatic reset_check;
        srst_i = 1'b1;
        repeat (16) @(negedge ref_clk_i);
        srst_i = 1'b0;
        @(negedge ref_clk_i);
        chk(dead_cycles_o, 23'd6);
        chk(wdog_cycles_o, 23'd500000);
        chk(chop_off_time_sel_cycles_o, 23'd1250);
        chk(wdog_on_o, 23'd0);
        chk({dead_time_sel_o, wdog_on_o, gate_current_sel_o}, 23'h7);
        chk({sense_out_clamp_o, overcurrent_trip_sel_o, monitor_off_o}, 23'h70);
        chk({regulation_off_o, ref_scale_sel_o, sample_hold_on_o}, 23'h0);
        chk(amp_gain_sel_o, 23'h1);
        chk(locked_o, 23'h0);
        chk(rvalid_o, 23'h0);
        i_hbc_host.write_reg(8'h10, 8'hFF);
        rd_chk(8'h10, 8'h00);
        rd_chk(`HBC_ADDR_GATE, 8'h07);
        rd_chk(`HBC_ADDR_MON, 8'h70);
        rd_chk(`HBC_ADDR_REG, 8'h01);
    endtask : reset_check
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            report_and_stop();
        end
    end
    initial begin
        reset_check();
        for (int i = 0; i < 8; i++) begin
            g = {i[1:0], i[0], i[1:0], i[2:0]};
            m = {i[0], i[2:0], i[3:0] ^ 4'hA};
            r = {i[1:0], i[2], i[1:0], i[0], i[2:1]};
            i_hbc_host.write_reg(`HBC_ADDR_GATE, g);
            i_hbc_host.write_reg(`HBC_ADDR_MON, m);
            i_hbc_host.write_reg(`HBC_ADDR_REG, r);
            rd_chk(`HBC_ADDR_GATE, g);
            rd_chk(`HBC_ADDR_MON, m);
            rd_chk(`HBC_ADDR_REG, r);
            chk(rdata_o, r);
            chk(dead_cycles_o, 23'(6 << i[1:0]));
            chk(wdog_cycles_o, wd_tab[i[1:0]]);
            chk(chop_off_time_sel_cycles_o, 23'(1250 << i[1:0]));
            chk({dead_time_sel_o, wdog_on_o, gate_current_sel_o}, {g[7:5], g[2:0]});
            chk({sense_out_clamp_o, overcurrent_trip_sel_o, monitor_off_o}, m);
            chk({regulation_off_o, ref_scale_sel_o, sample_hold_on_o}, r[5:2]);
            chk(amp_gain_sel_o, r[1:0]);
        end
        i_hbc_host.write_reg(`HBC_ADDR_MAIN, 8'h30);
        chk(locked_o, 23'd1);
        rd_chk(`HBC_ADDR_MAIN, 8'h30);
        i_hbc_host.write_reg(`HBC_ADDR_MON, 8'h00);
        i_hbc_host.write_reg(`HBC_ADDR_GATE, 8'h00);
        i_hbc_host.write_reg(`HBC_ADDR_MAIN, 8'h00);
        chk(locked_o, 23'd1);
        rd_chk(`HBC_ADDR_MON, m);
        rd_chk(`HBC_ADDR_GATE, g);
        i_hbc_host.write_reg(`HBC_ADDR_MAIN, 8'h18);
        chk(locked_o, 23'd0);
        i_hbc_host.write_reg(`HBC_ADDR_MON, 8'h00);
        rd_chk(`HBC_ADDR_MON, 8'h00);
        reset_check();
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
